// >>> logic/fwcr_crc16.sv
// One byte step of a 16-bit CRC, most significant bit first.
module fwcr_crc16
#(
    parameter logic [15:0] POLY = 16'h1021
)
(
    // Running value and new byte
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data,
    // Updated value
    output logic      [15:0] crc_out
);

    // Shift the byte in bit by bit; the loop unrolls into a xor tree.
    always_comb
    begin
        logic [15:0] c;
        c = crc_in;
        for (int i = 7; i >= 0; i--)
        begin
            if (c[15] ^ data[i])
                c = {c[14:0], 1'b0} ^ POLY;
            else
                c = {c[14:0], 1'b0};
        end
        crc_out = c;
    end

endmodule // fwcr_crc16

// >>> logic/fwcr_defines.svh
// Constants of the firmware check and tuning register group.
//
// Operation
// [R1] Writing 0x15 to firmware control starts the CRC over the shadow firmware.
// [R2] CRC result reads as upper byte at 0x26, lower at 0x25; pass is BEEF.
// [R3] The two CRC bytes read in any order; no read-ordering latch.
// [R4] Firmware revision reads the revision only while running from shadow firmware, else 0x00.
// [R5] Lift threshold is 5 bits, resets to 0x10; higher value means higher lift.
// [R6] Y resolution acts only while independent-axis reporting is on.
// [R7] Y resolution is value times 90 cpi, resets 0x12; host writes 0x01 to 0x37.
// [R8] Size bit 1 picks image size, 0 is 1.5K and 1 is 3K bytes.
// [R9] CRC result stays stable until a new check or reset; reserved bits read zero.
`ifndef FWCR_DEFINES_SVH
`define FWCR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FWCR_ADDR_CRC_LOW   7'h25
`define FWCR_ADDR_CRC_HIGH  7'h26
`define FWCR_ADDR_LIFT      7'h2E
`define FWCR_ADDR_YRES      7'h2F
`define FWCR_ADDR_REV       7'h30
`define FWCR_ADDR_SIZE      7'h31
`define FWCR_ADDR_FW_CTRL   7'h13

// ----------------------------------------------------------------------------
// Field positions, reset values and commands
// ----------------------------------------------------------------------------
`define FWCR_LIFT_MSB       4
`define FWCR_SIZE_BIT       1
`define FWCR_LIFT_RESET     5'h10
`define FWCR_YRES_RESET     8'h12
`define FWCR_SIZE_RESET     1'h0
`define FWCR_CRC_START_CMD  8'h15
`define FWCR_CRC_PASS       16'hBEEF
`define FWCR_REV_ABSENT     8'h00
`define FWCR_CPI_STEP       15'h005A

// ----------------------------------------------------------------------------
// Image lengths in bytes, last address of each
// ----------------------------------------------------------------------------
`define FWCR_IMG_SMALL_LAST 12'h5FF
`define FWCR_IMG_LARGE_LAST 12'hBFF

`endif

// >>> logic/fwcr_pkg.sv
// Types shared by the firmware check and tuning register group.
package fwcr_pkg;

    // ------------------------------------------------------------------------
    // CRC walker states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        CRC_IDLE,
        CRC_READ,
        CRC_ADD
    } fwcr_crc_state_t;

    // ------------------------------------------------------------------------
    // Whole state of the top module
    // ------------------------------------------------------------------------
    typedef struct packed
    {
        fwcr_crc_state_t crc_state;
        logic [11:0]     fw_addr;
        logic            fw_rd_en;
        logic [15:0]     crc;
        logic [15:0]     crc_result;
        logic            crc_busy;
        logic [4:0]      lift_thr;
        logic [7:0]      y_res;
        logic            size_sel;
        logic [7:0]      rd_data;
        logic            lift_detect;
        logic [7:0]      y_res_active;
        logic [14:0]     y_cpi;
    } fwcr_state_t;

endpackage : fwcr_pkg

// >>> logic/fwcr_regs.sv
// Firmware check and tuning register group of the motion sensor.
`include "fwcr_defines.svh"

module fwcr_regs
#(
    parameter logic [15:0] CRC_POLY = 16'h1021,
    parameter logic [15:0] CRC_INIT = 16'hFFFF
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Register access from the serial port engine
    input  wire logic [6:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Shadow firmware store read port, one cycle latency
    output logic      [11:0] fw_rd_addr,
    output logic             fw_rd_en,
    input  wire logic [7:0]  fw_rd_data,
    // Firmware execution status
    input  wire logic        fw_running,
    input  wire logic        fw_loaded,
    input  wire logic [7:0]  fw_revision_byte,
    output logic             crc_busy,
    output logic             image_size_select,
    // Lift detection
    input  wire logic [7:0]  height_estimate,
    output logic      [4:0]  lift_threshold_value,
    output logic             lift_detect,
    // Resolution
    input  wire logic        indep_axis_mode,
    input  wire logic [7:0]  x_res_value,
    output logic      [7:0]  y_res_active,
    output logic      [14:0] y_cpi
);

    // ------------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------------
    // An even polynomial loses its lowest feedback term and weakens the check.
    if (CRC_POLY[0] == 1'b0)
    begin : g_poly_check
        $error("CRC polynomial must have its lowest bit set.");
    end

    // ------------------------------------------------------------------------
    // State and helpers
    // ------------------------------------------------------------------------
    fwcr_pkg::fwcr_state_t s;
    fwcr_pkg::fwcr_state_t next_s;
    logic [15:0]           crc_step;
    logic [7:0]            scale_res;
    logic [14:0]           scale_cpi;
    logic                  start_cmd;
    logic [11:0]           last_addr;

    fwcr_crc16
    #(
        .POLY    (CRC_POLY)
    )
    u_crc
    (
        .crc_in  (s.crc),
        .data    (fw_rd_data),
        .crc_out (crc_step)
    );

    fwcr_y_scale u_scale
    (
        .indep_axis_mode (indep_axis_mode),
        .y_res_value     (s.y_res),
        .x_res_value     (x_res_value),
        .res_active      (scale_res),
        .cpi             (scale_cpi)
    );

    // Start command and image length are decoded once for the walker.
    // [R1] Start command decode
    assign start_cmd = reg_wr && (reg_addr == `FWCR_ADDR_FW_CTRL) && (reg_wdata == `FWCR_CRC_START_CMD);
    // [R8] Image length select
    assign last_addr = s.size_sel ? `FWCR_IMG_LARGE_LAST : `FWCR_IMG_SMALL_LAST;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_s          = s;
        next_s.fw_rd_en = 1'b0;

        // Writable settings; reserved bits are simply not stored.
        if (reg_wr)
        begin
            unique case (reg_addr)
                // [R5] Five bit threshold
                `FWCR_ADDR_LIFT: next_s.lift_thr = reg_wdata[`FWCR_LIFT_MSB:0];
                // [R7] Y value stored
                `FWCR_ADDR_YRES: next_s.y_res    = reg_wdata;
                // [R8] Size bit stored
                `FWCR_ADDR_SIZE: next_s.size_sel = reg_wdata[`FWCR_SIZE_BIT];
                default:         next_s.y_res    = s.y_res;
            endcase
        end

        // The walker fetches a byte, then folds it in: two cycles per byte.
        unique case (s.crc_state)
            fwcr_pkg::CRC_IDLE:
            begin
                next_s.crc_state = fwcr_pkg::CRC_IDLE;
            end
            fwcr_pkg::CRC_READ:
            begin
                next_s.crc_state = fwcr_pkg::CRC_ADD;
            end
            fwcr_pkg::CRC_ADD:
            begin
                next_s.crc = crc_step;
                if (s.fw_addr == last_addr)
                begin
                    // [R9] Result held
                    next_s.crc_state  = fwcr_pkg::CRC_IDLE;
                    next_s.crc_busy   = 1'b0;
                    next_s.crc_result = crc_step;
                end
                else
                begin
                    next_s.crc_state = fwcr_pkg::CRC_READ;
                    next_s.fw_addr   = s.fw_addr + 12'h001;
                    next_s.fw_rd_en  = 1'b1;
                end
            end
            // The fourth code is never entered; fall back to idle if it ever is.
            default:
            begin
                next_s.crc_state = fwcr_pkg::CRC_IDLE;
                next_s.crc_busy  = 1'b0;
            end
        endcase

        // A new command always restarts the walk, even mid-check, and clears
        // the old result so a stale pass cannot be mistaken for a new one.
        // [R1] Check restart
        if (start_cmd)
        begin
            next_s.crc_state  = fwcr_pkg::CRC_READ;
            next_s.fw_addr    = 12'h000;
            next_s.fw_rd_en   = 1'b1;
            next_s.crc        = CRC_INIT;
            next_s.crc_result = 16'h0000;
            next_s.crc_busy   = 1'b1;
        end

        // Reads have no side effect, so byte order does not matter.
        // [R3] Order free read
        next_s.rd_data = 8'h00;
        if (reg_rd)
        begin
            unique case (reg_addr)
                // [R2] Result bytes
                `FWCR_ADDR_CRC_LOW:  next_s.rd_data = s.crc_result[7:0];
                `FWCR_ADDR_CRC_HIGH: next_s.rd_data = s.crc_result[15:8];
                // [R4] Revision gate
                `FWCR_ADDR_REV:      next_s.rd_data = (fw_running && fw_loaded) ? fw_revision_byte
                                                                                : `FWCR_REV_ABSENT;
                // [R9] Reserved read zero
                `FWCR_ADDR_LIFT:     next_s.rd_data = {3'h0, s.lift_thr};
                `FWCR_ADDR_YRES:     next_s.rd_data = s.y_res;
                `FWCR_ADDR_SIZE:     next_s.rd_data = {6'h00, s.size_sel, 1'b0};
                default:             next_s.rd_data = 8'h00;
            endcase
        end

        // Lift is reported once the height estimate passes the threshold,
        // so a larger threshold moves the trip point higher.
        // [R5] Threshold compare
        next_s.lift_detect  = height_estimate > {3'h0, s.lift_thr};
        next_s.y_res_active = scale_res;
        next_s.y_cpi        = scale_cpi;
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s              <= '0;
            s.crc_state    <= fwcr_pkg::CRC_IDLE;
            s.crc          <= CRC_INIT;
            s.lift_thr     <= `FWCR_LIFT_RESET;
            s.y_res        <= `FWCR_YRES_RESET;
            s.size_sel     <= `FWCR_SIZE_RESET;
            s.y_res_active <= 8'h00;
            s.y_cpi        <= 15'h0000;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs come straight from the state flip-flops.
    assign reg_rdata            = s.rd_data;
    assign fw_rd_addr           = s.fw_addr;
    assign fw_rd_en             = s.fw_rd_en;
    assign crc_busy             = s.crc_busy;
    assign image_size_select    = s.size_sel;
    assign lift_threshold_value = s.lift_thr;
    assign lift_detect          = s.lift_detect;
    assign y_res_active         = s.y_res_active;
    assign y_cpi                = s.y_cpi;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // [R1] Start begins walk
    crc_start_a: assert property (start_cmd |=> crc_busy && fw_rd_en && fw_rd_addr == 12'h000) // [R1]
        else $error("Start command did not begin the CRC walk.");

    // [R2] Upper byte read
    crc_high_a: assert property (reg_rd && reg_addr == `FWCR_ADDR_CRC_HIGH // [R2]
                                 |=> reg_rdata == $past(s.crc_result[15:8]))
        else $error("Upper CRC byte read back wrong.");

    // [R3] Low read harmless
    crc_order_a: assert property (reg_rd && reg_addr == `FWCR_ADDR_CRC_LOW && !start_cmd && !crc_busy // [R3]
                                  |=> $stable(s.crc_result) && reg_rdata == $past(s.crc_result[7:0]))
        else $error("Lower CRC byte read disturbed the result.");

    // [R4] Revision gating
    fw_rev_a: assert property (reg_rd && reg_addr == `FWCR_ADDR_REV // [R4]
                               |=> reg_rdata == ($past(fw_running && fw_loaded) ? $past(fw_revision_byte) : 8'h00))
        else $error("Firmware revision read wrong.");

    // [R5] Lift trip point
    lift_cmp_a: assert property ($past(rstn) // [R5]
                                 |-> lift_detect == $past(height_estimate > {3'h0, lift_threshold_value}))
        else $error("Lift report does not follow the threshold compare.");

    // [R6] Mode gates Y
    y_mode_a: assert property (!indep_axis_mode |=> y_res_active == $past(x_res_value)) // [R6]
        else $error("Y resolution applied outside independent mode.");

    // [R7] Cpi scaling
    y_cpi_a: assert property (y_cpi == 15'({7'h00, y_res_active} * `FWCR_CPI_STEP)) // [R7]
        else $error("Counts per inch not ninety times the setting.");

    // [R8] Small image bound
    img_size_a: assert property (fw_rd_en && !image_size_select |-> fw_rd_addr <= 12'h5FF) // [R8]
        else $error("Walk read past the small image.");

    // [R9] Result stability
    crc_hold_a: assert property (!crc_busy && !start_cmd |=> $stable(s.crc_result)) // [R9]
        else $error("CRC result changed without a new check.");

    // [R1] Start clears result
    crc_clear_a: assert property (start_cmd |=> s.crc_result == 16'h0000) // [R1]
        else $error("Start command did not clear the old result.");

    // [R1] Busy marks walk
    busy_state_a: assert property (crc_busy == (s.crc_state != fwcr_pkg::CRC_IDLE)) // [R1]
        else $error("Busy flag disagrees with the walker state.");

    // [R1] One fetch per byte
    rd_pulse_a: assert property (fw_rd_en && !start_cmd |=> !fw_rd_en) // [R1]
        else $error("Store read enable held longer than one cycle.");

    // [R3] Read data one cycle
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00) // [R3]
        else $error("Read data not zero outside a read.");

    // [R5] Threshold kept
    lift_keep_a: assert property (!(reg_wr && reg_addr == `FWCR_ADDR_LIFT) |=> $stable(lift_threshold_value)) // [R5]
        else $error("Lift threshold changed without a write.");

    // [R6] Indep uses Y
    y_indep_a: assert property (indep_axis_mode |=> y_res_active == $past(s.y_res)) // [R6]
        else $error("Stored Y resolution not applied in independent mode.");

    // [R7] Y value stored
    yres_write_a: assert property (reg_wr && reg_addr == `FWCR_ADDR_YRES |=> s.y_res == $past(reg_wdata)) // [R7]
        else $error("Y resolution write not stored.");

    // [R8] Large image bound
    img_large_a: assert property (fw_rd_en |-> fw_rd_addr <= 12'hBFF) // [R8]
        else $error("Walk read past the large image.");

    // [R8] Size bit kept
    size_keep_a: assert property (!(reg_wr && reg_addr == `FWCR_ADDR_SIZE) |=> $stable(image_size_select)) // [R8]
        else $error("Image size bit changed without a write.");

    // [R9] Lift reserved zero
    lift_rsvd_a: assert property (reg_rd && reg_addr == `FWCR_ADDR_LIFT |=> reg_rdata[7:5] == 3'h0) // [R9]
        else $error("Reserved lift threshold bits read nonzero.");

    // [R9] Size reserved zero
    size_rsvd_a: assert property (reg_rd && reg_addr == `FWCR_ADDR_SIZE // [R9]
                                  |=> {reg_rdata[7:2], reg_rdata[0]} == 7'h00)
        else $error("Reserved image size bits read nonzero.");

endmodule // fwcr_regs

// >>> logic/fwcr_y_scale.sv
// Picks the Y resolution in force and turns it into counts per inch.
`include "fwcr_defines.svh"

module fwcr_y_scale
(
    // Settings
    input  wire logic        indep_axis_mode,
    input  wire logic [7:0]  y_res_value,
    input  wire logic [7:0]  x_res_value,
    // Resolution in force
    output logic      [7:0]  res_active,
    output logic      [14:0] cpi
);

    // The stored Y value is ignored unless axes are reported independently.
    // [R6] Mode gated select
    always_comb
    begin
        res_active = indep_axis_mode ? y_res_value : x_res_value;
        // [R7] Ninety cpi step
        cpi        = 15'({7'h00, res_active} * `FWCR_CPI_STEP);
    end

endmodule // fwcr_y_scale

// >>> tb/fwcr_regs_tb_top.sv
// Self-checking bench of the firmware check and tuning register group.
`include "fwcr_defines.svh"

module firmware_check_and_tuning_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------------
    localparam logic [15:0] POLY = 16'h1021;
    localparam logic [15:0] INIT = 16'hFFFF;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [6:0]  reg_addr = 7'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic [11:0] fw_rd_addr;
    logic        fw_rd_en;
    logic [7:0]  fw_rd_data;
    logic        fw_running = 1'b0;
    logic        fw_loaded = 1'b0;
    logic [7:0]  fw_revision_byte = 8'h5C;
    logic        crc_busy;
    logic        image_size_select;
    logic [7:0]  height_estimate = 8'h00;
    logic [4:0]  lift_threshold_value;
    logic        lift_detect;
    logic        indep_axis_mode = 1'b0;
    logic [7:0]  x_res_value = 8'h20;
    logic [7:0]  y_res_active;
    logic [14:0] y_cpi;
    int          rd_count;
    logic        order_err;
    int          num_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;

    fwcr_regs #(.CRC_POLY(POLY), .CRC_INIT(INIT)) dut
    (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fw_rd_addr(fw_rd_addr), .fw_rd_en(fw_rd_en),
        .fw_rd_data(fw_rd_data), .fw_running(fw_running), .fw_loaded(fw_loaded),
        .fw_revision_byte(fw_revision_byte), .crc_busy(crc_busy), .image_size_select(image_size_select),
        .height_estimate(height_estimate), .lift_threshold_value(lift_threshold_value),
        .lift_detect(lift_detect), .indep_axis_mode(indep_axis_mode), .x_res_value(x_res_value),
        .y_res_active(y_res_active), .y_cpi(y_cpi)
    );

    fwcr_store_model store
    (
        .clk(clk), .fw_rd_addr(fw_rd_addr), .fw_rd_en(fw_rd_en), .fw_rd_data(fw_rd_data),
        .rd_count(rd_count), .order_err(order_err)
    );

    // Clock at 25 MHz; the ceiling leaves headroom over the two CRC runs.
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors = num_errors + 1;
            end_sim();
        end
    end

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    // Read data stands for one cycle only, so it is taken at the next falling edge.
    task automatic rd(input logic [6:0] a, output logic [7:0] v);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        v = reg_rdata;
        reg_rd = 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(name, {8'h00, exp}, {8'h00, v});
    endtask

    function automatic logic [15:0] crc_ref(input int n);
        logic [15:0] c;
        logic [7:0]  b;
        c = INIT;
        for (int k = 0; k < n; k++)
        begin
            b = 8'(k) ^ {4'h0, 4'(k >> 8)} ^ 8'hA5;
            for (int i = 7; i >= 0; i--)
                c = (c[15] ^ b[i]) ? ({c[14:0], 1'b0} ^ POLY) : {c[14:0], 1'b0};
        end
        return c;
    endfunction

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset;
        rdchk("lift reset", `FWCR_ADDR_LIFT, 8'h10);
        rdchk("yres reset", `FWCR_ADDR_YRES, 8'h12);
        rdchk("size reset", `FWCR_ADDR_SIZE, 8'h00);
        rdchk("unmapped", 7'h40, 8'h00);
        rdchk("crc reset", `FWCR_ADDR_CRC_HIGH, 8'h00);
        chk("lift out reset", 16'h0010, {11'h000, lift_threshold_value});
    endtask

    // Strict comparison: equal height must not report lift.
    task automatic t_lift;
        wr(`FWCR_ADDR_LIFT, 8'hE5);
        rdchk("lift reserved", `FWCR_ADDR_LIFT, 8'h05);
        height_estimate = 8'h05;
        repeat (2) @(negedge clk);
        chk("lift at equal", 16'h0000, {15'h0000, lift_detect});
        height_estimate = 8'h06;
        repeat (2) @(negedge clk);
        chk("lift above", 16'h0001, {15'h0000, lift_detect});
        wr(`FWCR_ADDR_LIFT, 8'h1F);
        repeat (2) @(negedge clk);
        chk("lift higher thr", 16'h0000, {15'h0000, lift_detect});
    endtask

    task automatic t_yres;
        wr(`FWCR_ADDR_YRES, 8'h37);
        repeat (2) @(negedge clk);
        chk("y shared", 16'h0020, {8'h00, y_res_active});
        chk("y cpi shared", 16'h0B40, {1'b0, y_cpi});
        indep_axis_mode = 1'b1;
        repeat (2) @(negedge clk);
        chk("y indep", 16'h0037, {8'h00, y_res_active});
        chk("y cpi max", 16'h1356, {1'b0, y_cpi});
        wr(`FWCR_ADDR_YRES, 8'h01);
        repeat (2) @(negedge clk);
        chk("y cpi min", 16'h005A, {1'b0, y_cpi});
    endtask

    task automatic t_size_rev;
        wr(`FWCR_ADDR_SIZE, 8'hFF);
        rdchk("size bit", `FWCR_ADDR_SIZE, 8'h02);
        chk("size out", 16'h0001, {15'h0000, image_size_select});
        fw_loaded = 1'b1;
        rdchk("rev not running", `FWCR_ADDR_REV, 8'h00);
        fw_running = 1'b1;
        rdchk("rev running", `FWCR_ADDR_REV, 8'h5C);
        fw_loaded = 1'b0;
        rdchk("rev not loaded", `FWCR_ADDR_REV, 8'h00);
        wr(`FWCR_ADDR_SIZE, 8'h00);
    endtask

    // Runs one check and reads the result in both byte orders.
    task automatic t_crc(input int n);
        logic [15:0] e;
        e = crc_ref(n);
        wr(`FWCR_ADDR_FW_CTRL, 8'h15);
        rdchk("crc cleared", `FWCR_ADDR_CRC_LOW, 8'h00);
        for (int i = 0; i < 8000 && crc_busy !== 1'b0; i++)
            @(negedge clk);
        chk("crc done", 16'h0000, {15'h0000, crc_busy});
        chk("bytes read", 16'(n), 16'(rd_count));
        chk("read order", 16'h0000, {15'h0000, order_err});
        rdchk("crc high", `FWCR_ADDR_CRC_HIGH, e[15:8]);
        rdchk("crc low", `FWCR_ADDR_CRC_LOW, e[7:0]);
        repeat (20) @(negedge clk);
        rdchk("crc low first", `FWCR_ADDR_CRC_LOW, e[7:0]);
        rdchk("crc high held", `FWCR_ADDR_CRC_HIGH, e[15:8]);
    endtask

    // ------------------------------------------------------------------------
    // Main sequence and verdict
    // ------------------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        t_reset();
        t_lift();
        t_yres();
        t_size_rev();
        t_crc(1536);
        wr(`FWCR_ADDR_SIZE, 8'h02);
        t_crc(3072);
        rdchk("lift kept", `FWCR_ADDR_LIFT, 8'h1F);
        end_sim();
    end
endmodule // firmware_check_and_tuning_regs_tb_top

// >>> tb/fwcr_store_model.sv
// Model of the shadow firmware store that answers the block's byte reads.
module fwcr_store_model
(
    // Clock
    input  wire logic        clk,
    // Read port from the block
    input  wire logic [11:0] fw_rd_addr,
    input  wire logic        fw_rd_en,
    output logic      [7:0]  fw_rd_data,
    // Read bookkeeping
    output int               rd_count,
    output logic             order_err
);
    timeunit 1ns;
    timeprecision 1ns;

    // Image content: byte k of the downloaded firmware.
    function automatic logic [7:0] img(input logic [11:0] a);
        return a[7:0] ^ {4'h0, a[11:8]} ^ 8'hA5;
    endfunction

    initial
    begin
        fw_rd_data = 8'h00;
        rd_count = 0;
        order_err = 1'b0;
    end

    // firmware under check
    // Outside a read the byte turns over, so a stale sample never matches by luck.
    always @(posedge clk)
    begin
        if (fw_rd_en)
        begin
            fw_rd_data <= img(fw_rd_addr);
            rd_count <= (fw_rd_addr == 12'h000) ? 1 : rd_count + 1;
            order_err <= order_err | ((fw_rd_addr != 12'h000) && (int'(fw_rd_addr) != rd_count));
        end
        else
            fw_rd_data <= ~fw_rd_data;
    end
endmodule // fwcr_store_model
